// >>> rtl/can_acceptance_filter.sv
// identifier acceptance filter with code/ignore registers and receive hand-off
// What this block does
// R01: keep message in background; forward only accepted
// R02: compare identifier bytes bit by bit
// R03: extended uses four pairs, standard two
// R04: code byte compared, result qualified by ignore
// R05: ignore bit 0 demands equal bit
// R06: ignore bit 1 skips; all compared must match
// R07: software ignores three low bits, 32-bit standard
// R08: software ignores three low bits, 16-bit standard
// R09: read anytime, write only in init mode
// R10: organization selects 32/16/8-bit or closed
// R11: closed organization accepts nothing
// R12: hit index follows foreground message
module can_acceptance_filter (
  input wire logic ref_clk, // 125 MHz clock
  input wire logic nrst, // async reset, active low
  input wire can_filter_pkg::reg_req_t bus, // register request
  output logic [7:0] rdata, // read data, cycle after read strobe
  input wire logic init_acknowledge, // controller reports init mode
  output logic init_request, // software request for init mode
  input wire logic rx_valid, // one-cycle pulse: new message received
  input wire can_filter_pkg::rx_msg_t rx_msg, // received identifier
  output can_filter_pkg::rx_msg_t fg_msg, // foreground buffer identifier
  output logic fg_load, // one-cycle pulse: foreground reloaded
  output logic [2:0] filter_hit_index, // filter that accepted fg_msg
  output logic irq // level interrupt
);
  import can_filter_pkg::*;

  logic [NUM_FILT-1:0][7:0] code_byte;
  logic [NUM_FILT-1:0][7:0] ignore_byte;
  org_t filter_organization;
  rx_msg_t bg_msg;
  logic pending;
  logic [NUM_FILT-1:0] hit8;
  logic [3:0] hit16;
  logic [1:0] hit32;
  logic [NUM_FILT-1:0] hit_vec;
  logic accept;
  logic [HIT_W-1:0] hit_sel;
  logic init_mode;
  logic [EV_W-1:0] irq_status;
  logic [EV_W-1:0] irq_mask;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] clr_bits;
  logic [7:0] next_rdata;

  // identifier bit must equal code bit unless ignored; all must agree
  // R02 bitwise compare
  // R04 qualified by ignore
  // R05 zero demands equal
  // R06 one skips bit
  function automatic logic byte_match(input logic [7:0] id, input logic [7:0] code,
                                      input logic [7:0] ign);
    byte_match = &(~(id ^ code) | ign);
  endfunction

  function automatic logic [HIT_W-1:0] lowest_set(input logic [NUM_FILT-1:0] v);
    lowest_set = HIT_RST;
    for (int i = NUM_FILT - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest_set = HIT_W'(i);
      end
    end
  endfunction

  function automatic logic is_code_addr(input logic [ADDR_W-1:0] a);
    is_code_addr = (a >= CODE_BASE) && (a < IGNORE_BASE);
  endfunction

  function automatic logic is_ignore_addr(input logic [ADDR_W-1:0] a);
    is_ignore_addr = (a >= IGNORE_BASE) && (a < CTRL_ADDR);
  endfunction

  assign init_mode = init_request && init_acknowledge;

  // register writes

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      init_request <= 1'b0;
    end else if (bus.wr && bus.addr == CTRL_ADDR) begin
      init_request <= bus.wdata[CTRL_INIT_BIT];
    end
  end

  // configuration is frozen outside init mode so a live filter never glitches
  // R09 write gate
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      filter_organization <= ORG_TWO32;
    end else if (bus.wr && bus.addr == CTRL_ADDR && init_mode) begin
      filter_organization <= org_t'(bus.wdata[CTRL_ORG_MSB:CTRL_ORG_LSB]);
    end
  end

  // R09 write gate
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      code_byte <= {NUM_FILT{CODE_RST}};
    end else if (bus.wr && is_code_addr(bus.addr) && init_mode) begin
      code_byte[bus.addr[HIT_W-1:0]] <= bus.wdata;
    end
  end

  // R09 write gate
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ignore_byte <= {NUM_FILT{IGNORE_RST}};
    end else if (bus.wr && is_ignore_addr(bus.addr) && init_mode) begin
      ignore_byte[bus.addr[HIT_W-1:0]] <= bus.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask <= EV_ZERO;
    end else if (bus.wr && bus.addr == IRQ_MASK_ADDR) begin
      irq_mask <= bus.wdata[EV_W-1:0];
    end
  end

  // receive path

  // a new message always overwrites the background copy; one under
  // evaluation in the same cycle is judged from the old copy first
  // R01 background store
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bg_msg <= MSG_RST;
    end else if (rx_valid) begin
      bg_msg <= rx_msg;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pending <= 1'b0;
    end else begin
      pending <= rx_valid;
    end
  end

  // per-filter hit terms for every organization
  for (genvar f = 0; f < NUM_FILT; f++) begin : g_filt
    assign hit8[f] = byte_match(bg_msg.identifier_bytes[0], code_byte[f], ignore_byte[f]);
    if (f < 4) begin : g_16
      assign hit16[f] =
        byte_match(bg_msg.identifier_bytes[0], code_byte[2*f], ignore_byte[2*f]) &&
        byte_match(bg_msg.identifier_bytes[1], code_byte[2*f+1], ignore_byte[2*f+1]);
    end
    if (f < 2) begin : g_32
      // R03 standard uses two pairs
      assign hit32[f] =
        byte_match(bg_msg.identifier_bytes[0], code_byte[4*f], ignore_byte[4*f]) &&
        byte_match(bg_msg.identifier_bytes[1], code_byte[4*f+1], ignore_byte[4*f+1]) &&
        (!bg_msg.extended ||
         (byte_match(bg_msg.identifier_bytes[2], code_byte[4*f+2], ignore_byte[4*f+2]) &&
          byte_match(bg_msg.identifier_bytes[3], code_byte[4*f+3], ignore_byte[4*f+3])));
    end
  end

  // R10 organization select
  // R11 closed accepts none
  always_comb begin
    hit_vec = '0;
    unique case (filter_organization)
      ORG_TWO32: hit_vec = {6'h00, hit32};
      ORG_FOUR16: hit_vec = {4'h0, hit16};
      ORG_EIGHT8: hit_vec = hit8;
      ORG_CLOSED: hit_vec = '0;
    endcase
  end

  // when several filters hit, the lowest numbered one is reported
  assign accept = pending && (|hit_vec);
  assign hit_sel = lowest_set(hit_vec);

  // R01 forward accepted only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fg_msg <= MSG_RST;
    end else if (accept) begin
      fg_msg <= bg_msg;
    end
  end

  // R12 hit index update
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      filter_hit_index <= HIT_RST;
    end else if (accept) begin
      filter_hit_index <= hit_sel;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fg_load <= 1'b0;
    end else begin
      fg_load <= accept;
    end
  end

  // interrupts

  assign events = {pending && !accept, accept};
  assign clr_bits = (bus.wr && bus.addr == IRQ_STAT_ADDR) ? bus.wdata[EV_W-1:0] : EV_ZERO;

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_status <= EV_ZERO;
    end else begin
      irq_status <= (irq_status & ~clr_bits) | events;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // register reads

  // R09 read anytime
  always_comb begin
    next_rdata = BYTE_ZERO;
    if (bus.rd) begin
      if (is_code_addr(bus.addr)) begin
        next_rdata = code_byte[bus.addr[HIT_W-1:0]];
      end else if (is_ignore_addr(bus.addr)) begin
        next_rdata = ignore_byte[bus.addr[HIT_W-1:0]];
      end else if (bus.addr == CTRL_ADDR) begin
        next_rdata[CTRL_INIT_BIT] = init_request;
        next_rdata[CTRL_ORG_MSB:CTRL_ORG_LSB] = filter_organization;
      end else if (bus.addr == STAT_ADDR) begin
        next_rdata[STAT_HIT_MSB:STAT_HIT_LSB] = filter_hit_index;
        next_rdata[STAT_ACK_BIT] = init_acknowledge;
      end else if (bus.addr == IRQ_STAT_ADDR) begin
        next_rdata[EV_W-1:0] = irq_status;
      end else if (bus.addr == IRQ_MASK_ADDR) begin
        next_rdata[EV_W-1:0] = irq_mask;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= BYTE_ZERO;
    end else begin
      rdata <= next_rdata;
    end
  end

  // assertions

  AST_WRITE_LOCKED: assert property (@(posedge ref_clk) disable iff (!nrst) // R09
    bus.wr && bus.addr == CODE_BASE && !init_mode |=> code_byte[0] == $past(code_byte[0]))
    else $error("code byte changed outside init mode");

  AST_WRITE_TAKEN: assert property (@(posedge ref_clk) disable iff (!nrst) // R09
    bus.wr && bus.addr == IGNORE_BASE && init_mode |=> ignore_byte[0] == $past(bus.wdata))
    else $error("ignore byte write in init mode lost");

  AST_READ_CODE: assert property (@(posedge ref_clk) disable iff (!nrst) // R09
    bus.rd && bus.addr == CODE_BASE |=> rdata == $past(code_byte[0]) ##1
      (rdata == BYTE_ZERO || $past(bus.rd)))
    else $error("code byte read back wrong");

  AST_CLOSED: assert property (@(posedge ref_clk) disable iff (!nrst) // R11
    pending && filter_organization == ORG_CLOSED |=> !fg_load && $stable(fg_msg))
    else $error("closed filter reloaded foreground");

  AST_ACCEPT_LOADS: assert property (@(posedge ref_clk) disable iff (!nrst) // R01
    rx_valid ##1 accept |=> fg_load && fg_msg == $past(bg_msg) && irq_status[EV_ACCEPT])
    else $error("accepted message not forwarded");

  AST_DROP: assert property (@(posedge ref_clk) disable iff (!nrst) // R01
    pending && !accept |=> !fg_load && irq_status[EV_DROP])
    else $error("rejected message forwarded");

  AST_HIT_INDEX: assert property (@(posedge ref_clk) disable iff (!nrst) // R12
    fg_load |-> filter_hit_index == $past(hit_sel) && filter_hit_index <= HIT_W'(7))
    else $error("hit index not updated with foreground");

  AST_STD_TWO_PAIRS: assert property (@(posedge ref_clk) disable iff (!nrst) // R03
    pending && filter_organization == ORG_TWO32 && !bg_msg.extended &&
    byte_match(bg_msg.identifier_bytes[0], code_byte[0], ignore_byte[0]) &&
    byte_match(bg_msg.identifier_bytes[1], code_byte[1], ignore_byte[1])
    |-> accept && hit_sel == HIT_RST)
    else $error("standard identifier rejected by two matching pairs");

  AST_ALL_IGNORED: assert property (@(posedge ref_clk) disable iff (!nrst) // R06
    pending && filter_organization == ORG_EIGHT8 && ignore_byte[3] == BYTE_ALL
    |-> accept && hit_sel <= HIT_W'(3))
    else $error("fully ignored filter did not accept");

  AST_BIT_MISMATCH: assert property (@(posedge ref_clk) disable iff (!nrst) // R05
    pending && filter_organization == ORG_EIGHT8 &&
    ((bg_msg.identifier_bytes[0] ^ code_byte[0]) & ~ignore_byte[0]) != BYTE_ZERO
    |-> !accept || hit_sel != HIT_RST)
    else $error("unignored mismatching bit still hit filter 0");

  AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (!nrst) // R01
    irq_mask[EV_ACCEPT] && $rose(irq_status[EV_ACCEPT]) |-> irq)
    else $error("unmasked event did not raise interrupt");

endmodule

// >>> rtl/can_filter_pkg.sv
// constants and carrier types of the identifier acceptance filter
package can_filter_pkg;

  localparam int ADDR_W = 8;
  localparam int NUM_FILT = 8;
  localparam int HIT_W = 3;

  // register byte addresses
  localparam logic [ADDR_W-1:0] CODE_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] IGNORE_BASE = 8'h08;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h11;
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 8'h12;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'h13;

  // control register fields
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_ORG_LSB = 4;
  localparam int CTRL_ORG_MSB = 5;
  // status register fields
  localparam int STAT_HIT_LSB = 0;
  localparam int STAT_HIT_MSB = 2;
  localparam int STAT_ACK_BIT = 7;
  // interrupt event bits
  localparam int EV_ACCEPT = 0;
  localparam int EV_DROP = 1;
  localparam int EV_W = 2;

  // reset values
  localparam logic [7:0] CODE_RST = 8'h00;
  localparam logic [7:0] IGNORE_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ALL = 8'hff;
  localparam logic [HIT_W-1:0] HIT_RST = 3'h0;
  localparam logic [EV_W-1:0] EV_ZERO = 2'h0;

  typedef enum logic [1:0] {
    ORG_TWO32 = 2'b00,
    ORG_FOUR16 = 2'b01,
    ORG_EIGHT8 = 2'b10,
    ORG_CLOSED = 2'b11
  } org_t;

  // identifier_bytes[0] is the first identifier byte on the bus
  typedef struct packed {
    logic extended;
    logic [3:0][7:0] identifier_bytes;
  } rx_msg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  localparam rx_msg_t MSG_RST = '0;

endpackage

// >>> verif/can_rx_partner.sv
// far-side model: controller init handshake and receive hand-off
module can_rx_partner #(
  parameter int ACK_DLY = 4
) (
  input wire logic ref_clk, // bus clock
  input wire logic nrst, // async reset, active low
  input wire logic init_request, // from the filter block
  output logic init_acknowledge, // init mode reached
  input wire logic send, // bench: deliver msg_in
  input wire can_filter_pkg::rx_msg_t msg_in, // message to deliver
  output logic rx_valid, // one-cycle pulse
  output can_filter_pkg::rx_msg_t rx_msg // identifier to the filter
);
  import can_filter_pkg::*;
  logic [ACK_DLY-1:0] ack_pipe;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_pipe <= '0;
    end else begin
      ack_pipe <= {ack_pipe[ACK_DLY-2:0], init_request};
    end
  end
  assign init_acknowledge = ack_pipe[ACK_DLY-1];
  // every reception handed over
  // outside the pulse the lines carry junk so a stale copy cannot pass
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_valid <= 1'b0;
      rx_msg <= MSG_RST;
    end else begin
      rx_valid <= send;
      rx_msg <= send ? msg_in : ~rx_msg;
    end
  end
endmodule

// >>> verif/can_acceptance_filter_tb_top.sv
// self-checking bench for the acceptance filter
module can_acceptance_filter_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import can_filter_pkg::*;
  logic ref_clk, nrst, init_acknowledge, init_request, rx_valid, fg_load, irq, send;
  logic [7:0] rdata;
  logic [2:0] filter_hit_index, exp_hit;
  reg_req_t bus;
  rx_msg_t rx_msg, fg_msg, msg_in, exp_fg;
  logic [7:0] cfg [16];
  logic [31:0] seed = 32'h0000_9c0f;
  int err_count = 0;
  int n_compared = 0;

  can_acceptance_filter u_dut (.ref_clk(ref_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
    .init_acknowledge(init_acknowledge), .init_request(init_request), .rx_valid(rx_valid),
    .rx_msg(rx_msg), .fg_msg(fg_msg), .fg_load(fg_load), .filter_hit_index(filter_hit_index),
    .irq(irq));
  can_rx_partner #(.ACK_DLY(4)) u_far (.ref_clk(ref_clk), .nrst(nrst),
    .init_request(init_request), .init_acknowledge(init_acknowledge), .send(send),
    .msg_in(msg_in), .rx_valid(rx_valid), .rx_msg(rx_msg));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int pos(input int o, input int f, input int k);
    return (o == 0) ? 4 * f + k : (o == 1) ? 2 * f + k : f;
  endfunction

  // lowest accepting filter wins, so scan from the top down
  function automatic logic judge(input int o, input rx_msg_t m, output logic [2:0] idx);
    int nf, nb;
    logic ok, hit;
    nf = (o == 3) ? 0 : 2 << o;
    nb = (o == 0 && !m.extended) ? 2 : 4 >> o;
    hit = 1'b0;
    idx = 3'h0;
    for (int f = nf - 1; f >= 0; f--) begin
      ok = 1'b1;
      for (int k = 0; k < nb; k++)
        if (((cfg[pos(o, f, k)] ^ m.identifier_bytes[k]) & ~cfg[8 + pos(o, f, k)]) != 8'h00)
          ok = 1'b0;
      if (ok) begin
        hit = 1'b1;
        idx = 3'(f);
      end
    end
    return hit;
  endfunction

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rx(input logic [32:0] got, input logic [32:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s is %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1;
    chk_reg(rdata, e);
  endtask

  task automatic rx_one(input int o);
    rx_msg_t m;
    logic acc;
    logic [2:0] idx;
    logic [31:0] tmp;
    int f;
    tmp = rnd();
    m.identifier_bytes = rnd();
    m.extended = tmp[0];
    // outside the closed organization, half the messages are built to pass one filter, ignored bits scrambled
    if (tmp[1] && o != 3) begin
      f = int'(tmp[10:8]) >> (2 - o);
      for (int k = 0; k < (4 >> o); k++)
        m.identifier_bytes[k] = cfg[pos(o, f, k)] ^ (tmp[23:16] & cfg[8 + pos(o, f, k)]);
    end
    acc = judge(o, m, idx);
    @(posedge ref_clk);
    send <= 1'b1;
    msg_in <= m;
    @(posedge ref_clk);
    send <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    if (acc) begin
      exp_fg = m;
      exp_hit = idx;
    end
    chk_rx(33'(fg_load), 33'(acc), "load");
    chk_rx(fg_msg, exp_fg, "foreground");
    chk_rx(33'(filter_hit_index), 33'(exp_hit), "hit");
    chk_rx(33'(irq), 33'(acc), "irq");
    rd(IRQ_STAT_ADDR, {6'h00, ~acc, acc});
    wr(IRQ_STAT_ADDR, 8'h03);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // about twenty times the expected run
  initial begin
    #160000;
    err_count++;
    conclude();
  end

  initial begin
    nrst = 1'b0;
    bus = '0;
    send = 1'b0;
    msg_in = MSG_RST;
    exp_fg = MSG_RST;
    exp_hit = HIT_RST;
    for (int i = 0; i < 16; i++) cfg[i] = 8'h00;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 16; i++) rd(8'(i), 8'h00);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    wr(CODE_BASE, 8'h5a);
    rd(CODE_BASE, 8'h00);
    wr(IRQ_MASK_ADDR, 8'h01);
    for (int o = 0; o < 4; o++) begin
      wr(CTRL_ADDR, 8'h01);
      wr(CODE_BASE, ~cfg[0]);
      rd(CODE_BASE, cfg[0]);
      for (int t = 0; t < 20 && init_acknowledge !== 1'b1; t++) @(posedge ref_clk);
      rd(STAT_ADDR, {1'b1, 4'h0, exp_hit});
      for (int i = 0; i < 16; i++) cfg[i] = (i < 8) ? 8'(rnd()) : 8'(rnd() & rnd());
      // low bits ignored for standard frames
      cfg[9] |= 8'h07;
      cfg[13] |= 8'h07;
      if (o == 1) begin
        cfg[11] |= 8'h07;
        cfg[15] |= 8'h07;
      end
      // corner case: a fully ignored 8-bit filter must pass every message
      if (o == 2) begin
        cfg[11] = 8'hff;
      end
      for (int i = 0; i < 16; i++) begin
        wr(8'(i), cfg[i]);
        rd(8'(i), cfg[i]);
      end
      wr(CTRL_ADDR, 8'(o << 4));
      rd(CTRL_ADDR, 8'(o << 4));
      repeat (20) rx_one(o);
    end
    conclude();
  end
endmodule
